// ### logic/flag_clear_unit.sv
// Operation
// [RULE1] Receive-level flag when level exceeds threshold.
// [RULE2] Receive threshold above depth stores depth; the code clamps the low five bits to depth minus 1.
// [RULE3] Transmit-low flag when level at/below threshold.
// [RULE4] Transmit threshold above depth stores depth; the code clamps the low five bits to depth minus 1.
// [RULE5] Combined read clears soft flags and causes.
// [RULE6] Combined read leaves level flags alone.
// [RULE7] Abort cause bit 9 survives clear reads.
// [RULE8] Underflow clear read clears bit 0.
// [RULE9] Receive-overflow clear read clears bit 1.
// [RULE10] Transmit-overflow clear read clears bit 3.
// [RULE11] Read-request clear read clears bit 5.
// [RULE12] Abort clear read clears bit 6, causes.
// [RULE13] Abort clear read releases transmit flush.
// [RULE14] Slave-done clear read clears bit 7.
// [RULE15] Transmit FIFO held flushed while abort set.
// [RULE16] Receive-level flag self-clears below threshold.
// [RULE17] Depth 32; write when full sets overflow.
// [RULE18] Hold clock low while read request pending.
// [RULE19] Reserved bits read zero, writes ignored.
`timescale 1ns/1ns
module flag_clear_unit
  import flag_clear_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   rstn_in,
  input  wire logic [31:0]            reg_addr_in,
  input  wire logic                   reg_read_in,
  input  wire logic                   reg_write_in,
  input  wire logic [REG_WIDTH-1:0]   reg_wdata_in,
  input  wire logic [5:0]             rx_level_in,
  input  wire logic [5:0]             tx_level_in,
  input  wire logic                   rx_underflow_event_in,
  input  wire logic                   rx_overflow_event_in,
  input  wire logic                   tx_write_in,
  input  wire logic                   read_request_event_in,
  input  wire logic                   slave_done_event_in,
  input  wire logic                   abort_event_in,
  input  wire logic [ABORT_WIDTH-1:0] abort_cause_in,
  input  wire logic                   tx_data_supplied_in,
  output logic [REG_WIDTH-1:0]        reg_rdata_out,
  output logic [FLAG_COUNT-1:0]       raw_flag_status_out,
  output logic [ABORT_WIDTH-1:0]      abort_cause_register_out,
  output logic                        tx_flush_out,
  output logic                        tx_overflow_reject_out,
  output logic                        scl_hold_low_out
);

  // The threshold field is five bits wide, so depth can only reach 32.
  // The check runs at elaboration, so a bad depth never reaches a netlist.
  if (DEPTH < 1 || DEPTH > FIFO_DEPTH) begin : g_depth_check
    $error("DEPTH must lie between 1 and 32.");
  end

  localparam logic [5:0] DEPTH_L    = 6'(DEPTH);
  localparam logic [4:0] DEPTH_MAX  = 5'(DEPTH - 1);

  // Everything the block remembers lives in one packed record.
  // The thresholds hold the clamped codes, never the raw written value.
  // The flags field is the raw flag status exactly as software sees it.
  // The abort cause accumulates until a clear read removes all of it except bit 9.
  // The read data is registered, which costs one cycle of latency but keeps
  // the register port free of combinational paths from the address decode.
  typedef struct packed {
    logic [THRESHOLD_WIDTH-1:0] receive_threshold_level;
    logic [THRESHOLD_WIDTH-1:0] transmit_threshold_level;
    logic [FLAG_COUNT-1:0]      flags;
    logic [ABORT_WIDTH-1:0]     abort_cause;
    logic                       flush;
    logic                       overflow_reject;
    logic                       scl_hold;
    logic [REG_WIDTH-1:0]       rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // A written threshold whose low five bits lie beyond the buffer is pinned to the largest usable value.
  function automatic logic [4:0] clamp_threshold(input logic [REG_WIDTH-1:0] value);
    if (value[THRESHOLD_WIDTH-1:0] > DEPTH_MAX) begin
      clamp_threshold = DEPTH_MAX;
    end else begin
      clamp_threshold = value[THRESHOLD_WIDTH-1:0];
    end
  endfunction

  // Register read strobe for one address.
  function automatic logic read_hit(input logic [31:0] addr, input logic [31:0] target);
    read_hit = reg_read_in && (addr == target);
  endfunction

  logic combined_clear;
  logic underflow_clear;
  logic receive_overflow_clear;
  logic transmit_overflow_clear;
  logic read_request_clear;
  logic abort_clear;
  logic slave_done_clear;
  logic tx_full;

  // Decode the clear-on-read addresses once; the combined read also feeds each flag.
  // Folding the combined read into every single clear keeps one clear path per
  // flag, so the combined read can never disagree with the dedicated reads.
  // The full test uses the live level, which the transmit buffer reports
  // in the same cycle as the write that it refuses.
  always_comb begin
    combined_clear          = read_hit(reg_addr_in, ADDR_CLEAR_ALL_FLAGS);
    underflow_clear         = read_hit(reg_addr_in, ADDR_CLEAR_READ_UNDERFLOW) || combined_clear;
    receive_overflow_clear  = read_hit(reg_addr_in, ADDR_CLEAR_RECEIVE_OVER) || combined_clear;
    transmit_overflow_clear = read_hit(reg_addr_in, ADDR_CLEAR_TRANSMIT_OVER) || combined_clear;
    read_request_clear      = read_hit(reg_addr_in, ADDR_CLEAR_READ_REQUEST) || combined_clear;
    abort_clear             = read_hit(reg_addr_in, ADDR_CLEAR_TRANSMIT_ABORT) || combined_clear;
    slave_done_clear        = read_hit(reg_addr_in, ADDR_CLEAR_SLAVE_DONE) || combined_clear;
    tx_full                 = (tx_level_in >= DEPTH_L);
  end

  // Next-state logic. Every hardware set wins over a clear read in the same cycle.
  // Order inside this process matters: the clear of a flag is written first and
  // the matching set second, so the later assignment decides a collision.
  // Thresholds written in one cycle act on the level flags from the next cycle,
  // because the compare uses the stored code and not the written data.
  // Level flags are recomputed every cycle and therefore clear by themselves
  // once the buffer level moves across the threshold.
  always_comb begin
    next_st = st;

    // Threshold registers; only the low five bits are kept.
    if (reg_write_in && reg_addr_in == ADDR_RECEIVE_THRESHOLD) begin
      next_st.receive_threshold_level = clamp_threshold(reg_wdata_in); // [RULE2] [RULE19]
    end
    if (reg_write_in && reg_addr_in == ADDR_TRANSMIT_THRESHOLD) begin
      next_st.transmit_threshold_level = clamp_threshold(reg_wdata_in); // [RULE4] [RULE19]
    end

    // Level flags follow the FIFO levels and ignore every clear read.
    next_st.flags[FLAG_RX_LEVEL] =
      (rx_level_in >= ({1'b0, st.receive_threshold_level} + 6'h01)); // [RULE1] [RULE6] [RULE16]
    next_st.flags[FLAG_TX_LOW] =
      (tx_level_in <= {1'b0, st.transmit_threshold_level}); // [RULE3] [RULE6]

    // Sticky flags set by hardware events and cleared only by software reads.
    // An event that meets a clear read in the same cycle survives it. Losing an
    // event there would hide a real fault, which is worse than one extra read.

    // Receive underflow: the processor read an empty receive buffer.
    if (underflow_clear) begin
      next_st.flags[FLAG_RX_UNDER] = 1'b0; // [RULE8] [RULE5]
    end
    if (rx_underflow_event_in) begin
      next_st.flags[FLAG_RX_UNDER] = 1'b1;
    end

    // Receive overflow: a byte arrived while the receive buffer was full.
    if (receive_overflow_clear) begin
      next_st.flags[FLAG_RX_OVER] = 1'b0; // [RULE9] [RULE5]
    end
    if (rx_overflow_event_in) begin
      next_st.flags[FLAG_RX_OVER] = 1'b1;
    end

    // Transmit overflow: a write was issued while the transmit buffer was full.
    if (transmit_overflow_clear) begin
      next_st.flags[FLAG_TX_OVER] = 1'b0; // [RULE10] [RULE5]
    end
    if (tx_write_in && tx_full) begin
      next_st.flags[FLAG_TX_OVER] = 1'b1; // [RULE17]
    end

    // Slave read request: a remote master wants data from this side.
    if (read_request_clear) begin
      next_st.flags[FLAG_READ_REQ] = 1'b0; // [RULE11] [RULE5]
    end
    if (read_request_event_in) begin
      next_st.flags[FLAG_READ_REQ] = 1'b1;
    end

    // Slave transmit done: the remote master stopped acknowledging our bytes.
    if (slave_done_clear) begin
      next_st.flags[FLAG_SLAVE_DONE] = 1'b0; // [RULE14] [RULE5]
    end
    if (slave_done_event_in) begin
      next_st.flags[FLAG_SLAVE_DONE] = 1'b1;
    end

    // Abort flag, its cause register and the transmit flush travel together.
    // Causes accumulate until cleared, so two aborts before one clear read
    // report the union of their reasons.
    if (abort_clear) begin
      next_st.flags[FLAG_TX_ABORT] = 1'b0; // [RULE12] [RULE5]
      next_st.abort_cause = st.abort_cause & ABORT_KEEP_MASK; // [RULE7] [RULE12]
      next_st.flush = 1'b0; // [RULE13]
    end
    if (abort_event_in) begin
      next_st.flags[FLAG_TX_ABORT] = 1'b1;
      next_st.abort_cause = next_st.abort_cause | abort_cause_in;
      next_st.flush = 1'b1; // [RULE15]
    end
    // The flush cannot drop while the flag still stands.
    if (next_st.flags[FLAG_TX_ABORT]) begin
      next_st.flush = 1'b1; // [RULE15]
    end

    // Writes are turned away when the FIFO is full or flushed.
    // A refused write is lost; the processor must wait for the abort clear
    // read before it refills the transmit buffer.
    next_st.overflow_reject = tx_write_in && (tx_full || st.flush); // [RULE17] [RULE13]

    // The clock stays held from a read request until data is supplied.
    // The hold follows the request event, not the sticky flag: software may
    // leave the flag standing long after it has answered, and the bus must
    // not stall for that. A new request in the supply cycle re-arms it.
    if (tx_data_supplied_in) begin
      next_st.scl_hold = 1'b0;
    end
    if (read_request_event_in) begin
      next_st.scl_hold = 1'b1; // [RULE18]
    end

    // Read data is registered, so it appears one cycle after the read strobe.
    next_st.rdata = READ_ZERO;
    if (reg_read_in) begin
      case (reg_addr_in)
        ADDR_RECEIVE_THRESHOLD: begin
          next_st.rdata = {11'h000, st.receive_threshold_level}; // [RULE19]
        end
        ADDR_TRANSMIT_THRESHOLD: begin
          next_st.rdata = {11'h000, st.transmit_threshold_level}; // [RULE19]
        end
        // Single clear registers report their flag in bit 0; the combined one reports the OR of all eight raw flags.
        ADDR_CLEAR_ALL_FLAGS: begin
          next_st.rdata = {15'h0000, |st.flags};
        end
        ADDR_CLEAR_READ_UNDERFLOW: begin
          next_st.rdata = {15'h0000, st.flags[FLAG_RX_UNDER]};
        end
        ADDR_CLEAR_RECEIVE_OVER: begin
          next_st.rdata = {15'h0000, st.flags[FLAG_RX_OVER]};
        end
        ADDR_CLEAR_TRANSMIT_OVER: begin
          next_st.rdata = {15'h0000, st.flags[FLAG_TX_OVER]};
        end
        ADDR_CLEAR_READ_REQUEST: begin
          next_st.rdata = {15'h0000, st.flags[FLAG_READ_REQ]};
        end
        ADDR_CLEAR_TRANSMIT_ABORT: begin
          next_st.rdata = {15'h0000, st.flags[FLAG_TX_ABORT]};
        end
        ADDR_CLEAR_SLAVE_DONE: begin
          next_st.rdata = {15'h0000, st.flags[FLAG_SLAVE_DONE]};
        end
        default: begin
          next_st.rdata = READ_ZERO;
        end
      endcase
    end
  end

  // All state in one register bank.
  // The reset branch loads constants only, so the asynchronous path stays
  // free of logic and the reset release is clean.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '{THRESHOLD_RESET, THRESHOLD_RESET, FLAGS_RESET, ABORT_RESET,
              1'b0, 1'b0, 1'b0, READ_ZERO};
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  // No gate sits between a flip-flop and a pin, so the far side sees
  // glitch-free levels for a full cycle.
  always_comb begin
    reg_rdata_out            = st.rdata;
    raw_flag_status_out      = st.flags;
    abort_cause_register_out = st.abort_cause;
    tx_flush_out             = st.flush;
    tx_overflow_reject_out   = st.overflow_reject;
    scl_hold_low_out         = st.scl_hold;
  end

endmodule

// ### inc/flag_clear_pkg.sv
package flag_clear_pkg;

  // Register byte addresses on the register port.
  localparam logic [31:0] ADDR_RECEIVE_THRESHOLD    = 32'h5000_1338;
  localparam logic [31:0] ADDR_TRANSMIT_THRESHOLD   = 32'h5000_133C;
  localparam logic [31:0] ADDR_CLEAR_ALL_FLAGS      = 32'h5000_1340;
  localparam logic [31:0] ADDR_CLEAR_READ_UNDERFLOW = 32'h5000_1344;
  localparam logic [31:0] ADDR_CLEAR_RECEIVE_OVER   = 32'h5000_1348;
  localparam logic [31:0] ADDR_CLEAR_TRANSMIT_OVER  = 32'h5000_134C;
  localparam logic [31:0] ADDR_CLEAR_READ_REQUEST   = 32'h5000_1350;
  localparam logic [31:0] ADDR_CLEAR_TRANSMIT_ABORT = 32'h5000_1354;
  localparam logic [31:0] ADDR_CLEAR_SLAVE_DONE     = 32'h5000_1358;

  // Register widths and field layout.
  localparam int          REG_WIDTH       = 16;
  localparam int          THRESHOLD_WIDTH = 5;
  localparam int          FIFO_DEPTH      = 32;
  localparam logic [4:0]  THRESHOLD_RESET = 5'h00;
  localparam logic [15:0] READ_ZERO       = 16'h0000;

  // Raw flag status bit positions.
  localparam int FLAG_RX_UNDER   = 0;
  localparam int FLAG_RX_OVER    = 1;
  localparam int FLAG_RX_LEVEL   = 2;
  localparam int FLAG_TX_OVER    = 3;
  localparam int FLAG_TX_LOW     = 4;
  localparam int FLAG_READ_REQ   = 5;
  localparam int FLAG_TX_ABORT   = 6;
  localparam int FLAG_SLAVE_DONE = 7;
  localparam int FLAG_COUNT      = 8;

  // Abort cause layout; the bit at ABORT_KEEP_BIT survives the clear reads.
  localparam int          ABORT_WIDTH     = 16;
  localparam int          ABORT_KEEP_BIT  = 9;
  localparam logic [15:0] ABORT_KEEP_MASK = 16'h0200;
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [15:0] ABORT_RESET     = 16'h0000;

endpackage

// ### tb/flag_clear_unit_assertions.sv
`timescale 1ns/1ns
module flag_clear_checker
  import flag_clear_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic        core_clk_in,
  input wire logic        rstn_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic        reg_read_in,
  input wire logic [5:0]  tx_level_in,
  input wire logic        rx_underflow_event_in,
  input wire logic        rx_overflow_event_in,
  input wire logic        tx_write_in,
  input wire logic        read_request_event_in,
  input wire logic        slave_done_event_in,
  input wire logic        abort_event_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [7:0]  raw_flag_status_out,
  input wire logic [15:0] abort_cause_register_out,
  input wire logic        tx_flush_out,
  input wire logic        scl_hold_low_out
);
  logic quiet;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // A clear loses to an event that sets the same flag in that cycle; quiet rules out every event.
  assign quiet = !(rx_underflow_event_in | rx_overflow_event_in | tx_write_in
                   | read_request_event_in | slave_done_event_in | abort_event_in);
  sequence s_clr(logic [31:0] a);
    reg_read_in && reg_addr_in == a ##0 quiet;
  endsequence
  chk_under_clear: assert property (
    s_clr(ADDR_CLEAR_READ_UNDERFLOW) |=> !raw_flag_status_out[0]) else $error("bit0 kept");
  chk_rxover_clear: assert property (
    s_clr(ADDR_CLEAR_RECEIVE_OVER) |=> !raw_flag_status_out[1]) else $error("bit1 kept");
  chk_txover_clear: assert property (
    s_clr(ADDR_CLEAR_TRANSMIT_OVER) |=> !raw_flag_status_out[3]) else $error("bit3 kept");
  chk_rdreq_clear: assert property (
    s_clr(ADDR_CLEAR_READ_REQUEST) |=> !raw_flag_status_out[5]) else $error("bit5 kept");
  chk_done_clear: assert property (
    s_clr(ADDR_CLEAR_SLAVE_DONE) |=> !raw_flag_status_out[7]) else $error("bit7 kept");
  chk_abort_clear: assert property (
    s_clr(ADDR_CLEAR_TRANSMIT_ABORT) |=> !raw_flag_status_out[6] && !tx_flush_out
    && (abort_cause_register_out & ~ABORT_KEEP_MASK) == 16'h0000) else $error("abort kept");
  chk_all_clear: assert property (
    s_clr(ADDR_CLEAR_ALL_FLAGS) |=> (raw_flag_status_out & 8'hEB) == 8'h00
    && (abort_cause_register_out & ~ABORT_KEEP_MASK) == 16'h0000)
    else $error("combined clear missed");
  chk_flush_hold: assert property (
    raw_flag_status_out[6] |-> tx_flush_out) else $error("flush dropped");
  chk_full_write: assert property (
    tx_write_in && tx_level_in == 6'(DEPTH) |=> raw_flag_status_out[3]) else $error("no overflow");
  chk_scl_hold: assert property (
    read_request_event_in |=> scl_hold_low_out) else $error("scl not held");
  chk_idle_zero: assert property (
    !reg_read_in |=> reg_rdata_out == READ_ZERO) else $error("idle rdata not zero");
endmodule
bind flag_clear_unit flag_clear_checker #(.DEPTH(DEPTH)) i_chk (.core_clk_in, .rstn_in,
  .reg_addr_in, .reg_read_in, .tx_level_in, .rx_underflow_event_in, .rx_overflow_event_in,
  .tx_write_in, .read_request_event_in, .slave_done_event_in, .abort_event_in, .reg_rdata_out,
  .raw_flag_status_out, .abort_cause_register_out, .tx_flush_out, .scl_hold_low_out);

// ### tb/far_side_model.sv
`timescale 1ns/1ns
module far_side_model (
  input  wire logic   clk_in,
  output logic [5:0]  rx_level_out,
  output logic [5:0]  tx_level_out,
  output logic [4:0]  event_out,
  output logic [15:0] cause_out
);
  // Quiet levels from time zero, owned by this model alone.
  initial begin
    event_out = 5'h00;
    cause_out = 16'h0000;
    rx_level_out = 6'h00;
    tx_level_out = 6'h00;
  end
  // The cause bus is inverted after each pulse so a stale value never looks valid.
  task automatic fire(input logic [4:0] m, input logic [15:0] c);
    @(negedge clk_in);
    event_out = m;
    cause_out = c;
    @(negedge clk_in);
    event_out = 5'h00;
    cause_out = ~c;
  endtask
  task automatic levels(input logic [5:0] r, input logic [5:0] t);
    @(negedge clk_in);
    rx_level_out = r;
    tx_level_out = t;
  endtask
endmodule

// ### tb/tb_flag_clear_unit.sv
`timescale 1ns/1ns
module tb_flag_clear_unit;
  import flag_clear_pkg::*;
  localparam int D = 16;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, txw = 0, sup = 0, flush, rej, scl;
  logic [31:0] addr = 32'h0000_0000;
  logic [15:0] wdata = 16'h0000, rdata, cause_reg, got;
  logic [7:0] raw;
  logic [5:0] rxl, txl;
  logic [4:0] ev;
  logic [15:0] cause;
  int fail_count = 0, checks_done = 0;
  logic [31:0] ca [6] = '{ADDR_CLEAR_READ_UNDERFLOW, ADDR_CLEAR_RECEIVE_OVER,
    ADDR_CLEAR_TRANSMIT_OVER, ADDR_CLEAR_READ_REQUEST, ADDR_CLEAR_SLAVE_DONE,
    ADDR_CLEAR_TRANSMIT_ABORT};
  int fb [6] = '{0, 1, 3, 5, 7, 6};
  logic [4:0] em [6] = '{5'h01, 5'h02, 5'h00, 5'h04, 5'h08, 5'h10};
  far_side_model i_far (.clk_in(clk), .rx_level_out(rxl), .tx_level_out(txl),
    .event_out(ev), .cause_out(cause));
  flag_clear_unit #(.DEPTH(D)) i_dut (.core_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
    .reg_read_in(rd), .reg_write_in(wr), .reg_wdata_in(wdata), .rx_level_in(rxl),
    .tx_level_in(txl), .rx_underflow_event_in(ev[0]), .rx_overflow_event_in(ev[1]),
    .tx_write_in(txw), .read_request_event_in(ev[2]), .slave_done_event_in(ev[3]),
    .abort_event_in(ev[4]), .abort_cause_in(cause), .tx_data_supplied_in(sup),
    .reg_rdata_out(rdata), .raw_flag_status_out(raw), .abort_cause_register_out(cause_reg),
    .tx_flush_out(flush), .tx_overflow_reject_out(rej), .scl_hold_low_out(scl));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobes last one cycle; read data stands only in the cycle after the strobe.
  task automatic rc(input logic [31:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    chk("rdata", e, rdata);
  endtask
  task automatic wrt(input logic [31:0] a, input logic [15:0] v);
    @(negedge clk);
    addr = a;
    wr = 1;
    wdata = v;
    @(negedge clk);
    wr = 0;
    wdata = ~v;
  endtask
  task automatic pulse_tx(input bit s);
    @(negedge clk);
    if (s) sup = 1; else txw = 1;
    @(negedge clk);
    sup = 0;
    txw = 0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    chk("raw", 16'h0010, {8'h00, raw});
    rc(ADDR_RECEIVE_THRESHOLD, 16'h0000);
    // Oversized thresholds clamp to the largest legal code for a depth of D.
    wrt(ADDR_RECEIVE_THRESHOLD, 16'hFFFF);
    rc(ADDR_RECEIVE_THRESHOLD, 16'(D - 1));
    wrt(ADDR_TRANSMIT_THRESHOLD, 16'hFFF3);
    rc(ADDR_TRANSMIT_THRESHOLD, 16'(D - 1));
    rc(32'h5000_1330, 16'h0000);
    $display("test thresholds done");
    wrt(ADDR_RECEIVE_THRESHOLD, 16'hFFE3);
    wrt(ADDR_TRANSMIT_THRESHOLD, 16'h0003);
    // Level flags lag the levels by one cycle, so one rising edge passes before looking.
    i_far.levels(6'd3, 6'd3);
    @(negedge clk);
    chk("lvl", 16'h0010, {8'h00, raw & 8'h14});
    i_far.levels(6'd4, 6'd4);
    @(negedge clk);
    chk("lvl", 16'h0004, {8'h00, raw & 8'h14});
    i_far.levels(6'd3, 6'd4);
    @(negedge clk);
    chk("lvl", 16'h0000, {8'h00, raw & 8'h14});
    wrt(ADDR_RECEIVE_THRESHOLD, 16'h0000);
    wrt(ADDR_TRANSMIT_THRESHOLD, 16'h0000);
    i_far.levels(6'd1, 6'd0);
    @(negedge clk);
    chk("lvl", 16'h0014, {8'h00, raw & 8'h14});
    $display("test levels done");
    // The refusal pulse stands for one cycle, so it is looked at right after the write.
    for (int k = 0; k < 6; k++) begin
      if (k == 2) begin
        i_far.levels(6'd1, 6'(D));
        pulse_tx(0);
        chk("reject", 16'h0001, {15'h0000, rej});
        i_far.levels(6'd1, 6'd0);
      end else begin
        i_far.fire(em[k], 16'h0201);
      end
      chk("set", 16'h0001, {15'h0000, raw[fb[k]]});
      if (k == 3) chk("scl", 16'h0001, {15'h0000, scl});
      if (k == 3) pulse_tx(1);
      if (k == 5) chk("flush", 16'h0001, {15'h0000, flush});
      if (k == 5) pulse_tx(0);
      if (k == 5) chk("reject", 16'h0001, {15'h0000, rej});
      rc(ca[k], 16'h0001);
      chk("clr", 16'h0000, {15'h0000, raw[fb[k]]});
      if (k == 3) chk("scl", 16'h0000, {15'h0000, scl});
      if (k == 5) chk("flush", 16'h0000, {15'h0000, flush});
      if (k == 5) chk("cause", 16'h0200, cause_reg);
    end
    $display("test single clears done");
    i_far.fire(5'h1F, 16'hFFFF);
    chk("raw", 16'h00F7, {8'h00, raw});
    rc(ADDR_CLEAR_ALL_FLAGS, 16'h0001);
    chk("raw", 16'h0014, {8'h00, raw});
    chk("cause", 16'h0200, cause_reg);
    $display("test combined clear done");
    close_out();
  end
endmodule
